// file: hw/dsfc_defs.svh
// Constants for the slot data queue control block
`ifndef DSFC_DEFS_SVH
`define DSFC_DEFS_SVH

// ----------------------------------------------------------------
// Connection codes
// ----------------------------------------------------------------
`define DSFC_CONN_OFF   2'b00
`define DSFC_CONN_LINK  2'b10

// ----------------------------------------------------------------
// Slot select range
// ----------------------------------------------------------------
`define DSFC_SLOT_MIN   4'h3
`define DSFC_SLOT_MAX   4'hc
`define DSFC_SLOT_STEP  4'h1

// ----------------------------------------------------------------
// Queue geometry and reset values
// ----------------------------------------------------------------
`define DSFC_DEPTH      8
`define DSFC_WORD_W     16
`define DSFC_SLOT_W     4
`define DSFC_CTL_RST    16'h4000
`define DSFC_SKID_DEPTH 2

`endif

// file: hw/dsfc_pkg.sv
// Types shared by the slot data queue control block
`include "dsfc_defs.svh"

package dsfc_pkg;

  // ----------------------------------------------------------------
  // Control word layout, most significant field first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                    sticky_err;
    logic                    empty;
    logic                    full;
    logic                    unused_bit;
    logic                    dma_request_enable;
    logic [2:0]              irq_threshold;
    logic [3:0]              slot;
    logic                    stereo_mono_choice;
    logic                    reserved_path_bit;
    logic [1:0]              conn;
  } dsfc_ctl_t;

  // ----------------------------------------------------------------
  // Word arriving from the link for one slot
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`DSFC_SLOT_W-1:0] slot;
    logic [`DSFC_WORD_W-1:0] data;
  } dsfc_slot_t;

endpackage

// file: hw/dsfc_top.sv
// Transmit and receive slot data queues with their control words
`include "dsfc_defs.svh"

// Functional notes
// - Transmit connection field 00 detaches, 10 attaches the queue to the link.
// - Receive connection field 00 detaches, 10 attaches the queue to the link.
// - Bit 3 picks mono (one slot) or stereo (slot pair) binding.
// - Slot codes 3 to 12 select slot N; stereo adds N+1; 12 stereo barred.
// - Transmit interrupt level held while remaining words equal the threshold.
// - Receive interrupt level held once threshold plus one words are held.
// - Bit 11 enables DMA requests from the queue.
// - Transmit bit 13 reads full, read only.
// - Transmit empty flag reads one when no words are held.
// - Transmit bit 15 sticky underflow, cleared by writing one.
// - Receive bit 13 reads full, read only.
// - Receive bit 14 reads empty, read only.
// - Receive bit 15 sticky overflow, cleared by writing one.
// - Each queue holds eight sixteen-bit words.
// - Stereo words leave in queue order, one per matched request for slot N or N+1.
// - A matched link request on an empty transmit queue sets underflow.
// - A matched word into a full receive queue sets overflow.
module dsfc_top #(
  parameter int DEPTH = `DSFC_DEPTH
) (
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_b_i,
  // Control words
  input  wire logic                    tx_ctl_wr_i,
  input  wire dsfc_pkg::dsfc_ctl_t     tx_ctl_wdata_i,
  output wire dsfc_pkg::dsfc_ctl_t     tx_ctl_rdata_o,
  input  wire logic                    rx_ctl_wr_i,
  input  wire dsfc_pkg::dsfc_ctl_t     rx_ctl_wdata_i,
  output wire dsfc_pkg::dsfc_ctl_t     rx_ctl_rdata_o,
  // Core transmit data
  input  wire logic                    tx_wr_valid_i,
  input  wire logic [`DSFC_WORD_W-1:0] tx_wr_data_i,
  output logic                         tx_wr_ready_o,
  // Core receive data
  output logic                         rx_rd_valid_o,
  output wire logic [`DSFC_WORD_W-1:0] rx_rd_data_o,
  input  wire logic                    rx_rd_ready_i,
  // Link transmit slot requests
  input  wire logic                    tx_slot_req_i,
  input  wire logic [`DSFC_SLOT_W-1:0] tx_slot_num_i,
  output logic                         tx_slot_ack_o,
  output logic                         tx_slot_good_o,
  output logic [`DSFC_WORD_W-1:0]      tx_slot_data_o,
  // Link receive slot words
  input  wire logic                    rx_slot_valid_i,
  input  wire dsfc_pkg::dsfc_slot_t    rx_slot_i,
  // Interrupt and DMA requests
  output logic                         tx_irq_o,
  output logic                         rx_irq_o,
  output logic                         tx_dma_req_o,
  output logic                         rx_dma_req_o
);
  import dsfc_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int SW = $clog2(`DSFC_SKID_DEPTH) + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [SW-1:0] SKID_FULL = SW'(`DSFC_SKID_DEPTH);

  // ----------------------------------------------------------------
  // Slot binding and control word update
  // ----------------------------------------------------------------
  function automatic logic slot_hit(dsfc_ctl_t c, logic [`DSFC_SLOT_W-1:0] n);
    logic ok;
    ok = (c.conn == `DSFC_CONN_LINK)
      && (c.slot >= `DSFC_SLOT_MIN) && (c.slot <= `DSFC_SLOT_MAX)
      && !(c.stereo_mono_choice && (c.slot == `DSFC_SLOT_MAX));
    // Stereo serves slot N or N+1 alike, one queue word per matched request, in queue order
    slot_hit = ok && ((n == c.slot)
      || (c.stereo_mono_choice && (n == c.slot + `DSFC_SLOT_STEP)));
  endfunction

  function automatic dsfc_ctl_t ctl_write(dsfc_ctl_t q, dsfc_ctl_t w, logic wr);
    dsfc_ctl_t r;
    r = q;
    if (wr) begin
      r.conn               = w.conn;
      r.stereo_mono_choice = w.stereo_mono_choice;
      r.slot               = w.slot;
      r.irq_threshold      = w.irq_threshold;
      r.dma_request_enable = w.dma_request_enable;
    end
    r.reserved_path_bit = 1'b0;
    r.unused_bit        = 1'b0;
    ctl_write = r;
  endfunction

  // ----------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------
  logic [`DSFC_WORD_W-1:0] tx_mem_q [DEPTH];
  logic [AW-1:0]           tx_wp_q;
  logic [AW-1:0]           tx_rp_q;
  logic [CW-1:0]           tx_cnt_q;
  logic [CW-1:0]           tx_cnt_d;
  dsfc_ctl_t               tx_ctl_q;
  dsfc_ctl_t               tx_ctl_d;
  logic                    tx_push;
  logic                    tx_hit;
  logic                    tx_pop;
  logic                    tx_under;

  assign tx_push  = tx_wr_valid_i && tx_wr_ready_o;
  assign tx_hit   = tx_slot_req_i && slot_hit(tx_ctl_q, tx_slot_num_i);
  assign tx_pop   = tx_hit && (tx_cnt_q != '0);
  assign tx_under = tx_hit && (tx_cnt_q == '0);
  assign tx_cnt_d = tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
  assign tx_ctl_rdata_o = tx_ctl_q;

  always_comb begin
    tx_ctl_d = ctl_write(tx_ctl_q, tx_ctl_wdata_i, tx_ctl_wr_i);
    tx_ctl_d.full  = (tx_cnt_d == FULL_CNT);
    tx_ctl_d.empty = (tx_cnt_d == '0);
    // A new underflow wins over a clear in the same cycle
    tx_ctl_d.sticky_err = tx_under
      || (tx_ctl_q.sticky_err && !(tx_ctl_wr_i && tx_ctl_wdata_i.sticky_err));
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_ctl_q <= `DSFC_CTL_RST;
    end else begin
      tx_ctl_q <= tx_ctl_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (tx_push) begin
      tx_mem_q[tx_wp_q] <= tx_wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_wp_q        <= '0;
      tx_rp_q        <= '0;
      tx_cnt_q       <= '0;
      tx_wr_ready_o  <= 1'b1;
      tx_slot_ack_o  <= 1'b0;
      tx_slot_good_o <= 1'b0;
      tx_slot_data_o <= '0;
    end else begin
      tx_wp_q        <= tx_push ? tx_wp_q + 1'b1 : tx_wp_q;
      tx_rp_q        <= tx_pop ? tx_rp_q + 1'b1 : tx_rp_q;
      tx_cnt_q       <= tx_cnt_d;
      tx_wr_ready_o  <= (tx_cnt_d != FULL_CNT);
      tx_slot_ack_o  <= tx_hit;
      tx_slot_good_o <= tx_pop;
      tx_slot_data_o <= tx_pop ? tx_mem_q[tx_rp_q] : '0;
    end
  end

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------
  logic [`DSFC_WORD_W-1:0] rx_mem_q [DEPTH];
  logic [AW-1:0]           rx_wp_q;
  logic [AW-1:0]           rx_rp_q;
  logic [CW-1:0]           rx_cnt_q;
  logic [CW-1:0]           rx_cnt_d;
  dsfc_ctl_t               rx_ctl_q;
  dsfc_ctl_t               rx_ctl_d;
  logic                    rx_hit;
  logic                    rx_push;
  logic                    rx_over;
  logic                    rx_pop;
  logic [`DSFC_WORD_W-1:0] sk_q [`DSFC_SKID_DEPTH];
  logic [SW-1:0]           sk_n_q;
  logic [SW-1:0]           sk_n_d;
  logic                    sk_take;
  logic [CW:0]             rx_lvl_d;

  assign rx_hit   = rx_slot_valid_i && slot_hit(rx_ctl_q, rx_slot_i.slot);
  assign rx_push  = rx_hit && (rx_cnt_q != FULL_CNT);
  assign rx_over  = rx_hit && (rx_cnt_q == FULL_CNT);
  assign rx_pop   = (rx_cnt_q != '0) && (sk_n_q != SKID_FULL);
  assign sk_take  = rx_rd_valid_o && rx_rd_ready_i;
  assign rx_cnt_d = rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
  assign sk_n_d   = sk_n_q + SW'(rx_pop) - SW'(sk_take);
  assign rx_lvl_d = (CW + 1)'(rx_cnt_d) + (CW + 1)'(sk_n_d);
  assign rx_rd_data_o   = sk_q[0];
  assign rx_ctl_rdata_o = rx_ctl_q;

  always_comb begin
    rx_ctl_d = ctl_write(rx_ctl_q, rx_ctl_wdata_i, rx_ctl_wr_i);
    rx_ctl_d.full  = (rx_cnt_d == FULL_CNT);
    rx_ctl_d.empty = (rx_lvl_d == '0);
    // A new overflow wins over a clear in the same cycle
    rx_ctl_d.sticky_err = rx_over
      || (rx_ctl_q.sticky_err && !(rx_ctl_wr_i && rx_ctl_wdata_i.sticky_err));
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_ctl_q <= `DSFC_CTL_RST;
    end else begin
      rx_ctl_q <= rx_ctl_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rx_push) begin
      rx_mem_q[rx_wp_q] <= rx_slot_i.data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      rx_cnt_q <= '0;
    end else begin
      rx_wp_q  <= rx_push ? rx_wp_q + 1'b1 : rx_wp_q;
      rx_rp_q  <= rx_pop ? rx_rp_q + 1'b1 : rx_rp_q;
      rx_cnt_q <= rx_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry output buffer toward the core
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sk_q[0]       <= '0;
      sk_q[1]       <= '0;
      sk_n_q        <= '0;
      rx_rd_valid_o <= 1'b0;
    end else begin
      if (sk_take) begin
        sk_q[0] <= sk_q[1];
      end
      if (rx_pop) begin
        if ((sk_n_q - SW'(sk_take)) == '0) begin
          sk_q[0] <= rx_mem_q[rx_rp_q];
        end else begin
          sk_q[1] <= rx_mem_q[rx_rp_q];
        end
      end
      sk_n_q        <= sk_n_d;
      rx_rd_valid_o <= (sk_n_d != '0);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt levels and DMA requests
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // An empty queue matches the zero threshold held in reset
      tx_irq_o     <= 1'b1;
      rx_irq_o     <= 1'b0;
      tx_dma_req_o <= 1'b0;
      rx_dma_req_o <= 1'b0;
    end else begin
      tx_irq_o     <= (tx_cnt_d == CW'(tx_ctl_d.irq_threshold));
      rx_irq_o     <= (rx_lvl_d > (CW + 1)'(rx_ctl_d.irq_threshold));
      tx_dma_req_o <= tx_ctl_d.dma_request_enable && !tx_ctl_d.full;
      rx_dma_req_o <= rx_ctl_d.dma_request_enable && (sk_n_d != '0);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_tx_starve;
    tx_slot_req_i && slot_hit(tx_ctl_q, tx_slot_num_i) && (tx_cnt_q == '0);
  endsequence

  sequence s_tx_bad_answer;
    tx_slot_ack_o && !tx_slot_good_o && tx_ctl_q.sticky_err;
  endsequence

  AST_TX_DETACHED: assert property (
    tx_slot_req_i && (tx_ctl_q.conn != `DSFC_CONN_LINK) |=> !tx_slot_ack_o)
    else $error("transmit queue answered while detached");

  AST_RX_DETACHED: assert property (
    rx_slot_valid_i && (rx_ctl_q.conn != `DSFC_CONN_LINK)
    |=> rx_cnt_q <= $past(rx_cnt_q))
    else $error("receive queue took a word while detached");

  AST_STEREO_PAIR: assert property (
    tx_slot_req_i && (tx_ctl_q.conn == `DSFC_CONN_LINK) && tx_ctl_q.stereo_mono_choice
    && (tx_ctl_q.slot >= `DSFC_SLOT_MIN) && (tx_ctl_q.slot < `DSFC_SLOT_MAX)
    && (tx_slot_num_i == tx_ctl_q.slot + `DSFC_SLOT_STEP) |=> tx_slot_ack_o)
    else $error("stereo second slot not served");

  AST_SLOT_RANGE: assert property (
    tx_slot_req_i && ((tx_ctl_q.slot < `DSFC_SLOT_MIN) || (tx_ctl_q.slot > `DSFC_SLOT_MAX)
    || (tx_ctl_q.stereo_mono_choice && (tx_ctl_q.slot == `DSFC_SLOT_MAX)))
    |=> !tx_slot_ack_o)
    else $error("reserved slot code served");

  AST_TX_IRQ_LEVEL: assert property (
    tx_irq_o == (tx_cnt_q == CW'(tx_ctl_q.irq_threshold)))
    else $error("transmit interrupt level wrong");

  AST_RX_IRQ_LEVEL: assert property (
    rx_irq_o == ((CW + 1)'(rx_cnt_q) + (CW + 1)'(sk_n_q)
    > (CW + 1)'(rx_ctl_q.irq_threshold)))
    else $error("receive interrupt level wrong");

  AST_DMA_GATE: assert property (
    !tx_ctl_q.dma_request_enable |-> !tx_dma_req_o)
    else $error("transmit DMA request while disabled");

  AST_TX_FULL: assert property (
    (tx_ctl_q.full == (tx_cnt_q == FULL_CNT)) && (tx_wr_ready_o == !tx_ctl_q.full))
    else $error("transmit full flag or ready wrong");

  AST_TX_UNDERFLOW: assert property (
    s_tx_starve |=> s_tx_bad_answer)
    else $error("underflow not flagged");

  AST_TX_STICKY: assert property (
    tx_ctl_q.sticky_err && !(tx_ctl_wr_i && tx_ctl_wdata_i.sticky_err) |=> tx_ctl_q.sticky_err)
    else $error("underflow flag lost");

  AST_RX_OVERFLOW: assert property (
    rx_slot_valid_i && slot_hit(rx_ctl_q, rx_slot_i.slot) && rx_ctl_q.full
    |=> rx_ctl_q.sticky_err [*2])
    else $error("overflow not flagged");

  AST_TX_EMPTY: assert property (
    tx_ctl_q.empty == (tx_cnt_q == '0))
    else $error("transmit empty flag wrong");

  AST_RX_FLAGS: assert property (
    (rx_ctl_q.full == (rx_cnt_q == FULL_CNT))
    && (rx_ctl_q.empty == ((rx_cnt_q == '0) && (sk_n_q == '0))))
    else $error("receive full or empty flag wrong");

  AST_RX_STICKY: assert property (
    rx_ctl_q.sticky_err && !(rx_ctl_wr_i && rx_ctl_wdata_i.sticky_err) |=> rx_ctl_q.sticky_err)
    else $error("overflow flag lost");

endmodule

// file: test/dsfc_link_model.sv
// Link slot model: asks for transmit slot words and delivers receive slot words
module dsfc_link_model (
  // Clock
  input  wire logic                 clk_i,
  // Transmit slot side
  output logic                      tx_slot_req_o,
  output logic [3:0]                tx_slot_num_o,
  input  wire logic                 tx_slot_ack_i,
  input  wire logic                 tx_slot_good_i,
  input  wire logic [15:0]          tx_slot_data_i,
  // Receive slot side
  output logic                      rx_slot_valid_o,
  output dsfc_pkg::dsfc_slot_t      rx_slot_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import dsfc_pkg::*;

  // ----------------------------------------
  // Slot traffic
  // ----------------------------------------
  initial begin
    tx_slot_req_o   = 1'b0;
    tx_slot_num_o   = 4'h0;
    rx_slot_valid_o = 1'b0;
    rx_slot_o       = '0;
  end

  // Called just after an edge; answer is sampled just after the edge that takes the request
  task automatic request(input logic [3:0] num, output logic [17:0] answer);
    tx_slot_req_o = 1'b1;
    tx_slot_num_o = num;
    @(posedge clk_i);
    #1;
    tx_slot_req_o = 1'b0;
    tx_slot_num_o = ~num;
    answer        = {tx_slot_ack_i, tx_slot_good_i, tx_slot_data_i};
    // Let an edge pass so a following request never re-raises in this step
    @(posedge clk_i);
    #1;
  endtask

  // Idle slot lines show the inverse of the last word so stale data never looks valid
  task automatic deliver(input logic [3:0] slot, input logic [15:0] data);
    rx_slot_valid_o = 1'b1;
    rx_slot_o       = '{slot: slot, data: data};
    @(posedge clk_i);
    #1;
    rx_slot_valid_o = 1'b0;
    rx_slot_o       = ~rx_slot_o;
    @(posedge clk_i);
    #1;
  endtask
endmodule

// file: test/test_dsp_slot_data_fifo_control.sv
// Self-checking bench for the slot data queue control block
module test_dsp_slot_data_fifo_control;
  timeunit 1ns;
  timeprecision 100ps;
  import dsfc_pkg::*;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        tx_ctl_wr_i, rx_ctl_wr_i, tx_wr_valid_i, rx_rd_ready_i, tx_slot_req_i;
  logic        tx_wr_ready_o, rx_rd_valid_o, tx_slot_ack_o, tx_slot_good_o, rx_slot_valid_i;
  logic        tx_irq_o, rx_irq_o, tx_dma_req_o, rx_dma_req_o;
  dsfc_ctl_t   tx_ctl_wdata_i, rx_ctl_wdata_i, tx_ctl_rdata_o, rx_ctl_rdata_o;
  logic [15:0] tx_wr_data_i, rx_rd_data_o, tx_slot_data_o;
  logic [3:0]  tx_slot_num_i;
  dsfc_slot_t  rx_slot_i;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  dsfc_top #(.DEPTH(8)) u_dsfc_top (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .tx_ctl_wr_i(tx_ctl_wr_i), .tx_ctl_wdata_i(tx_ctl_wdata_i), .tx_ctl_rdata_o(tx_ctl_rdata_o),
    .rx_ctl_wr_i(rx_ctl_wr_i), .rx_ctl_wdata_i(rx_ctl_wdata_i), .rx_ctl_rdata_o(rx_ctl_rdata_o),
    .tx_wr_valid_i(tx_wr_valid_i), .tx_wr_data_i(tx_wr_data_i), .tx_wr_ready_o(tx_wr_ready_o),
    .rx_rd_valid_o(rx_rd_valid_o), .rx_rd_data_o(rx_rd_data_o), .rx_rd_ready_i(rx_rd_ready_i),
    .tx_slot_req_i(tx_slot_req_i), .tx_slot_num_i(tx_slot_num_i), .tx_slot_ack_o(tx_slot_ack_o),
    .tx_slot_good_o(tx_slot_good_o), .tx_slot_data_o(tx_slot_data_o),
    .rx_slot_valid_i(rx_slot_valid_i), .rx_slot_i(rx_slot_i), .tx_irq_o(tx_irq_o),
    .rx_irq_o(rx_irq_o), .tx_dma_req_o(tx_dma_req_o), .rx_dma_req_o(rx_dma_req_o));

  dsfc_link_model u_dsfc_link_model (
    .clk_i(ref_clk_i), .tx_slot_req_o(tx_slot_req_i), .tx_slot_num_o(tx_slot_num_i),
    .tx_slot_ack_i(tx_slot_ack_o), .tx_slot_good_i(tx_slot_good_o),
    .tx_slot_data_i(tx_slot_data_o), .rx_slot_valid_o(rx_slot_valid_i), .rx_slot_o(rx_slot_i));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_ctl(input logic rx, input logic [15:0] v);
    tx_ctl_wr_i    = !rx;
    rx_ctl_wr_i    = rx;
    tx_ctl_wdata_i = v;
    rx_ctl_wdata_i = v;
    tick();
    tx_ctl_wr_i = 1'b0;
    rx_ctl_wr_i = 1'b0;
    tick();
  endtask

  task automatic push(input logic [15:0] d);
    tx_wr_valid_i = 1'b1;
    tx_wr_data_i  = d;
    tick();
    tx_wr_valid_i = 1'b0;
    tick();
  endtask

  task automatic pull(input logic [15:0] exp);
    for (int n = 0; n < 8 && rx_rd_valid_o !== 1'b1; n++) begin
      tick();
    end
    chk(18'(rx_rd_valid_o), 18'h1);
    chk(18'(rx_rd_data_o), 18'(exp));
    rx_rd_ready_i = 1'b1;
    tick();
    rx_rd_ready_i = 1'b0;
    tick();
  endtask

  task automatic slot_req(input logic [3:0] num, input logic [17:0] exp);
    logic [17:0] ans;
    u_dsfc_link_model.request(num, ans);
    chk(ans, exp);
  endtask

  task automatic print_verdict();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_tx_fill_drain();
    wr_ctl(1'b0, 16'h0b32);
    chk(18'(tx_ctl_rdata_o), 18'h04b32);
    chk(18'(tx_dma_req_o), 18'h1);
    for (int i = 0; i < 8; i++) begin
      push(16'h1000 + 16'(i));
      chk(18'(tx_irq_o), 18'(i == 2));
    end
    chk(18'(tx_wr_ready_o), 18'h0);
    chk(18'(tx_ctl_rdata_o), 18'h02b32);
    chk(18'(tx_dma_req_o), 18'h0);
    push(16'hdead);
    slot_req(4'h4, 18'h0);
    for (int i = 0; i < 8; i++) begin
      slot_req(4'h3, {2'b11, 16'h1000 + 16'(i)});
    end
    chk(18'(tx_ctl_rdata_o), 18'h04b32);
    slot_req(4'h3, {2'b10, 16'h0});
    tick();
    chk(18'(tx_ctl_rdata_o), 18'h0cb32);
    wr_ctl(1'b0, 16'h8b32);
    chk(18'(tx_ctl_rdata_o), 18'h04b32);
  endtask

  task automatic t_tx_reserved_stereo();
    logic [15:0] bad [6] = '{16'h0031, 16'h0033, 16'h0030, 16'h0022, 16'h00d2, 16'h00ca};
    push(16'h55aa);
    for (int i = 0; i < 6; i++) begin
      wr_ctl(1'b0, bad[i]);
      slot_req(bad[i][7:4], 18'h0);
    end
    wr_ctl(1'b0, 16'h005a);
    push(16'ha001);
    push(16'hb002);
    slot_req(4'h5, {2'b11, 16'h55aa});
    slot_req(4'h5, {2'b11, 16'ha001});
    slot_req(4'h6, {2'b11, 16'hb002});
  endtask

  task automatic t_rx();
    wr_ctl(1'b1, 16'h0a42);
    chk(18'(rx_ctl_rdata_o), 18'h04a42);
    u_dsfc_link_model.deliver(4'h7, 16'hffff);
    for (int i = 0; i < 10; i++) begin
      u_dsfc_link_model.deliver(4'h4, 16'h2000 + 16'(i));
      tick(3);
      chk(18'(rx_irq_o), 18'(i >= 2));
    end
    chk(18'(rx_ctl_rdata_o), 18'h02a42);
    chk(18'(rx_dma_req_o), 18'h1);
    u_dsfc_link_model.deliver(4'h4, 16'h3333);
    tick(2);
    chk(18'(rx_ctl_rdata_o), 18'h0aa42);
    for (int i = 0; i < 10; i++) begin
      pull(16'h2000 + 16'(i));
    end
    tick(2);
    chk(18'(rx_ctl_rdata_o), 18'h0ca42);
    wr_ctl(1'b1, 16'h8a40);
    u_dsfc_link_model.deliver(4'h4, 16'h4444);
    tick(2);
    chk(18'(rx_ctl_rdata_o), 18'h04a40);
  endtask

  initial begin
    {tx_ctl_wr_i, rx_ctl_wr_i, tx_wr_valid_i, rx_rd_ready_i} = 4'h0;
    tx_ctl_wdata_i = '0;
    rx_ctl_wdata_i = '0;
    tx_wr_data_i   = 16'h0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    chk(18'(tx_ctl_rdata_o), 18'h04000);
    chk(18'(rx_ctl_rdata_o), 18'h04000);
    chk(18'(tx_wr_ready_o), 18'h1);
    t_tx_fill_drain();
    t_tx_reserved_stereo();
    t_rx();
    print_verdict();
  end
endmodule
